/* hw/osd_top.sv */
// Off-state phase diagnosis: forcing control, filtering, masking, flags, APB.
// Assumes pins and comparators are asynchronous; APB on ref_clk_i.
// Functional notes
// R1 - Check only while both gates held off
// R2 - Flags latch until fault gone and cleared
// R3 - 01 pull-up, 10 pull-down, else off
// R4 - Phase settings reset to zero
// R5 - Auto start when enabled and inputs low
// R6 - Rising drive input stops diagnosis at once
// R7 - Software sets phases 10, 01, 10
// R8 - All low-side flags zero: ground short
// R9 - HS2 zero, low-side ones: battery short
// R10 - Low-side patterns name open phase; ones ok
// R11 - Shorts reported for motor, not phase
// R12 - Low-side battery, high-side ground comparators
// R13 - Up/down counter filters each comparator
// R14 - Blanking masks filter after start
// R15 - Mask time 10/25/50/100 ms, reset 50
// R16 - Filter time nominally 100 us
// R17 - Restart clears filter and mask timer
`timescale 1ns/100ps
module osd_top import osd_pkg::*; #(
  parameter int FLT_LIM = FLT_CYC,    // R16
  parameter int BLK0    = BLANK0_CYC,
  parameter int BLK1    = BLANK1_CYC,
  parameter int BLK2    = BLANK2_CYC,
  parameter int BLK3    = BLANK3_CYC,
  parameter int BLK_W   = 24
) (
  input  wire logic         ref_clk_i,  // System clock
  input  wire logic         srst_i,     // Sync reset, high
  input  wire osd_apb_req_t apb_i,      // APB request
  output osd_apb_rsp_t      apb_o,      // APB answer
  input  wire logic [2:0]   hs_drv_i,   // High-side drive inputs
  input  wire logic [2:0]   ls_drv_i,   // Low-side drive inputs
  input  wire logic [2:0]   ls_cmp_i,   // Phase above battery-short threshold
  input  wire logic [2:0]   hs_cmp_i,   // Phase above ground-short threshold
  output logic [2:0]        pu_en_o,    // Pull-up source enables
  output logic [2:0]        pd_en_o,    // Pull-down source enables
  output logic              irq_o       // Interrupt, high level
);
  // Pin synchroniser, three stages
  logic [11:0] s1, s2, s3, stab, next_stab;
  always_comb begin
    next_stab = (s2 & ~(s2 ^ s3)) | (stab & (s2 ^ s3));
  end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      stab <= '0;
    end else begin
      s1   <= {hs_cmp_i, ls_cmp_i, hs_drv_i, ls_drv_i};
      s2   <= s1;
      s3   <= s2;
      stab <= next_stab;
    end
  end
  wire logic [2:0] ls_d = stab[2:0];
  wire logic [2:0] hs_d = stab[5:3];
  wire logic [2:0] ls_c = stab[8:6];
  wire logic [2:0] hs_c = stab[11:9];

  function automatic logic is_src(input logic [1:0] s);
    return s == SET_PU || s == SET_PD; // R3
  endfunction

  function automatic logic [BLK_W-1:0] blk_lim(input logic [1:0] sel);
    case (sel)
      2'b00:   blk_lim = BLK_W'(BLK0); // R15
      2'b01:   blk_lim = BLK_W'(BLK1);
      2'b10:   blk_lim = BLK_W'(BLK2);
      default: blk_lim = BLK_W'(BLK3);
    endcase
  endfunction

  function automatic osd_sum_t decode(input logic [2:0] ls, input logic hs2);
    // Shorts are reported for the motor as a whole
    if (ls == 3'b000) decode = SUM_SCG;                    // R8 R11
    else if (ls == 3'b111 && !hs2) decode = SUM_SCB;       // R9 R11
    else if (ls == 3'b110) decode = SUM_OPEN1;             // R10
    else if (ls == 3'b010) decode = SUM_OPEN2;             // R10
    else if (ls == 3'b011) decode = SUM_OPEN3;             // R10
    else if (ls == 3'b111) decode = SUM_NOFAULT;           // R10
    else decode = SUM_UNDEF;
  endfunction

  logic [7:0]  ctrl;
  logic [5:0]  flag_ok, istat, imask;
  logic [5:0]  clr_req;
  wire  [5:0]  set6 = ctrl[5:0];
  wire  [1:0]  blk_sel = ctrl[CTRL_BLANK_POS +: 2];

  // Per-phase run state and mask timers
  osd_state_t       st      [3];
  osd_state_t       next_st [3];
  logic [BLK_W-1:0] bcnt    [3];
  logic [BLK_W-1:0] next_bcnt [3];
  logic [1:0]       pset    [3];
  logic [2:0]       start, run, bdone;
  logic [2:0]       next_pu, next_pd;

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      next_st[p]   = st[p];
      next_bcnt[p] = bcnt[p];
      start[p]     = 1'b0;
      run[p]       = st[p] == ST_RUN;
      bdone[p]     = run[p] && bcnt[p] >= blk_lim(blk_sel);
      case (st[p])
        ST_IDLE: begin
          if (is_src(set6[2*p +: 2]) && !hs_d[p] && !ls_d[p]) begin // R1 R5
            next_st[p] = ST_RUN;
            start[p]   = 1'b1;
          end
        end
        ST_RUN: begin
          if (hs_d[p] || ls_d[p] || !is_src(set6[2*p +: 2])) begin // R6
            next_st[p] = ST_IDLE;
          end else if (set6[2*p +: 2] != pset[p]) begin
            start[p] = 1'b1; // R17
          end
        end
        default: next_st[p] = ST_IDLE;
      endcase
      if (start[p]) begin
        next_bcnt[p] = '0; // R17
      end else if (run[p] && !bdone[p]) begin
        next_bcnt[p] = bcnt[p] + 1'b1; // R14
      end
      next_pu[p] = next_st[p] == ST_RUN && set6[2*p +: 2] == SET_PU; // R3
      next_pd[p] = next_st[p] == ST_RUN && set6[2*p +: 2] == SET_PD; // R3
    end
  end

  always_ff @(posedge ref_clk_i) begin
    for (int p = 0; p < 3; p++) begin
      if (srst_i) begin
        st[p]   <= ST_IDLE;
        bcnt[p] <= '0;
        pset[p] <= '0;
      end else begin
        st[p]   <= next_st[p];
        bcnt[p] <= next_bcnt[p];
        pset[p] <= set6[2*p +: 2];
      end
    end
    if (srst_i) begin
      pu_en_o <= '0;
      pd_en_o <= '0;
    end else begin
      pu_en_o <= next_pu;
      pd_en_o <= next_pd;
    end
  end

  // Comparator filters: index 0..2 low side, 3..5 high side
  logic [5:0] filt, flt_rst, raw_flt, masked;
  genvar c;
  generate
    for (c = 0; c < 6; c++) begin : g_flt
      localparam int P = c % 3;
      // Low side faults when phase sits below the battery threshold,
      // high side when it rises above the ground-short threshold
      assign raw_flt[c] = (c < 3) ? !ls_c[P] : hs_c[P]; // R12
      assign flt_rst[c] = start[P] || !run[P];
      assign masked[c]  = filt[c] && bdone[P] && run[P]; // R14
      osd_filter #(
        .FLT_LIM (FLT_LIM),
        .CNT_W   (14)
      ) u_flt (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .restart_i (flt_rst[c]),
        .fault_i   (raw_flt[c]),
        .filt_o    (filt[c])
      );
    end
  endgenerate

  // Flags read 1 while healthy; a latched fault drops its flag
  logic [5:0] next_flag, next_istat;
  always_comb begin
    // A fault in the clearing cycle wins; clear needs the fault gone
    next_flag  = (flag_ok | (clr_req & ~filt)) & ~masked; // R2
    next_istat = istat | (flag_ok & ~next_flag);
    // Write-one clear; a flag falling in the same cycle still sets
    if (wr && apb_i.paddr == OFF_ISTAT) begin
      next_istat = (istat & ~apb_i.pwdata[5:0]) | (flag_ok & ~next_flag);
    end
  end

  // APB slave with one wait state
  logic        acc, wr;
  logic [7:0]  next_ctrl;
  logic [5:0]  next_imask;
  logic [31:0] rd;
  logic        hit;
  osd_apb_rsp_t next_rsp;
  osd_sum_t     sum;
  logic         setup_ok;

  always_comb begin
    acc = apb_i.psel && apb_i.penable && apb_o.pready;
    wr  = acc && apb_i.pwrite;
    sum = decode(flag_ok[2:0], flag_ok[4]);
    setup_ok = set6 == {SET_PD, SET_PU, SET_PD}; // R7
    hit = apb_i.paddr inside {OFF_CTRL, OFF_FLAGS, OFF_CLR, OFF_ISTAT, OFF_IMASK};
    rd  = '0;
    case (apb_i.paddr)
      OFF_CTRL:  rd[7:0] = ctrl;
      OFF_FLAGS: begin
        rd[5:0]                 = flag_ok;
        rd[FL_RUN_POS +: 3]     = run;
        rd[FL_SUM_POS +: 3]     = sum;
        rd[FL_SET_POS]          = setup_ok;
      end
      OFF_ISTAT: rd[5:0] = istat;
      OFF_IMASK: rd[5:0] = imask;
      default:   rd = '0;
    endcase
    next_rsp.pready  = apb_i.psel && apb_i.penable && !apb_o.pready;
    next_rsp.prdata  = next_rsp.pready && !apb_i.pwrite ? rd : '0;
    next_rsp.pslverr = next_rsp.pready && !hit;
    next_ctrl  = (wr && apb_i.paddr == OFF_CTRL) ? apb_i.pwdata[7:0] : ctrl;
    next_imask = (wr && apb_i.paddr == OFF_IMASK) ? apb_i.pwdata[5:0] : imask;
    clr_req    = (wr && apb_i.paddr == OFF_CLR) ? apb_i.pwdata[5:0] : '0;
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ctrl    <= CTRL_RST; // R4 R15
      imask   <= '0;
      istat   <= '0;
      flag_ok <= FLAG_RST;
      apb_o   <= '0;
      irq_o   <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      imask   <= next_imask;
      istat   <= next_istat;
      flag_ok <= next_flag;
      apb_o   <= next_rsp;
      irq_o   <= |(next_istat & next_imask);
    end
  end

  sequence s_started(int p);
    start[p] ##1 run[p];
  endsequence

  a_pull_exclusive: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R3
    (pu_en_o & pd_en_o) == 3'b000)
    else $error("pull-up and pull-down both on");
  a_run_gates_off: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R1
    $rose(run[0]) |-> $past(!hs_d[0] && !ls_d[0] && is_src(set6[1:0])))
    else $error("diagnosis started with a gate driven");
  a_stop_on_rise: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R6
    run[0] && $rose(hs_d[0] || ls_d[0]) |=> !run[0] && pu_en_o[0] == 1'b0)
    else $error("diagnosis kept running after drive input rose");
  a_reset_ctrl: assert property (@(posedge ref_clk_i) // R4
    srst_i |=> set6 == 6'h00 && blk_sel == 2'b10)
    else $error("control not at reset value");
  a_flag_hold: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R2
    !flag_ok[0] && filt[0] |=> !flag_ok[0])
    else $error("flag cleared while fault persists");
  a_blank_mask: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R14
    $fell(flag_ok[3]) |-> $past(bdone[0] && filt[3]))
    else $error("flag set inside mask time");
  a_blank_restart: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R17
    s_started(2) |-> bcnt[2] == '0 || bcnt[2] == BLK_W'(1))
    else $error("mask timer not restarted");
  a_scg_decode: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R8
    flag_ok[2:0] == 3'b000 |-> sum == SUM_SCG)
    else $error("ground short not reported");
  a_irq_level: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (istat & imask) != 6'h00 ##1 (istat & imask) != 6'h00 |-> irq_o)
    else $error("interrupt low with unmasked status");
  a_apb_wait: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    apb_i.psel && apb_i.penable && !apb_o.pready |=> apb_o.pready)
    else $error("apb answer late");
  // Decode of the fixed three-phase setup
  a_scb_decode: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R9
    flag_ok[2:0] == 3'b111 && !flag_ok[4] |-> sum == SUM_SCB)
    else $error("battery short not reported");
  a_open_decode: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R10
    flag_ok[2:0] == 3'b110 |-> sum == SUM_OPEN1)
    else $error("open phase one not reported");
  // Start needs no software strobe, only a valid setting and idle gates
  a_auto_start: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R5
    !run[0] && is_src(set6[1:0]) && !hs_d[0] && !ls_d[0] |=> run[0])
    else $error("diagnosis did not start");
  a_pu_setting: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R3
    pu_en_o[0] |-> run[0] && $past(set6[1:0]) == SET_PU)
    else $error("pull-up on without its setting");
  a_pd_setting: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R3
    pd_en_o[0] |-> run[0] && $past(set6[1:0]) == SET_PD)
    else $error("pull-down on without its setting");
  a_mask_hold: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R14
    !bdone[0] && flag_ok[0] |=> flag_ok[0])
    else $error("flag fell inside mask time");
  a_istat_set: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $fell(flag_ok[0]) |-> istat[0])
    else $error("status not set when flag fell");
endmodule

/* shared/osd_pkg.sv */
// Package for the off-state phase diagnosis block.
// Assumes a 100 MHz system clock and an APB register slave.
package osd_pkg;
  localparam int CLK_MHZ      = 100;
  localparam int FLT_TIME_US  = 100;
  localparam int BLANK0_MS    = 10;
  localparam int BLANK1_MS    = 25;
  localparam int BLANK2_MS    = 50;
  localparam int BLANK3_MS    = 100;
  localparam int FLT_CYC      = FLT_TIME_US * CLK_MHZ;
  localparam int BLANK0_CYC   = BLANK0_MS * 1000 * CLK_MHZ;
  localparam int BLANK1_CYC   = BLANK1_MS * 1000 * CLK_MHZ;
  localparam int BLANK2_CYC   = BLANK2_MS * 1000 * CLK_MHZ;
  localparam int BLANK3_CYC   = BLANK3_MS * 1000 * CLK_MHZ;

  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_FLAGS = 8'h04;
  localparam logic [7:0] OFF_CLR   = 8'h08;
  localparam logic [7:0] OFF_ISTAT = 8'h0c;
  localparam logic [7:0] OFF_IMASK = 8'h10;

  // Control: phase settings in [5:0] (two bits per phase), mask time in [7:6]
  localparam int CTRL_BLANK_POS = 6;
  localparam logic [7:0] CTRL_RST  = 8'h80;
  localparam logic [5:0] FLAG_RST  = 6'h3f;
  // Flags word: ok flags [5:0], run [8:6], summary [11:9], setup ok [12]
  localparam int FL_RUN_POS  = 6;
  localparam int FL_SUM_POS  = 9;
  localparam int FL_SET_POS  = 12;

  typedef enum logic [1:0] {
    SET_OFF0 = 2'b00,
    SET_PU   = 2'b01,
    SET_PD   = 2'b10,
    SET_OFF3 = 2'b11
  } osd_set_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } osd_state_t;

  typedef enum logic [2:0] {
    SUM_NOFAULT = 3'b000,
    SUM_SCG     = 3'b001,
    SUM_SCB     = 3'b010,
    SUM_OPEN1   = 3'b011,
    SUM_OPEN2   = 3'b100,
    SUM_OPEN3   = 3'b101,
    SUM_UNDEF   = 3'b110
  } osd_sum_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } osd_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } osd_apb_rsp_t;
endpackage

/* hw/osd_filter.sv */
// Up/down counter deglitch filter for one comparator.
// Assumes fault_i is already synchronised to ref_clk_i.
`timescale 1ns/100ps
module osd_filter import osd_pkg::*; #(
  parameter int FLT_LIM = FLT_CYC,
  parameter int CNT_W   = 14
) (
  input  wire logic ref_clk_i,  // System clock
  input  wire logic srst_i,     // Sync reset, high
  input  wire logic restart_i,  // Diagnosis (re)start
  input  wire logic fault_i,    // Raw fault level
  output logic      filt_o      // Filtered fault
);
  localparam logic [CNT_W-1:0] LIM = CNT_W'(FLT_LIM);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             next_filt;

  always_comb begin
    next_cnt  = cnt;
    next_filt = filt_o;
    if (restart_i) begin
      next_cnt  = '0; // R17
      next_filt = 1'b0;
    end else if (fault_i && cnt != LIM) begin
      next_cnt = cnt + 1'b1; // R13
    end else if (!fault_i && cnt != '0) begin
      next_cnt = cnt - 1'b1; // R13
    end
    // Hysteresis: output follows only the two ends of the count
    if (!restart_i && next_cnt == LIM) begin
      next_filt = 1'b1;
    end else if (next_cnt == '0) begin
      next_filt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt    <= '0;
      filt_o <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      filt_o <= next_filt;
    end
  end

  a_count_up: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R13
    fault_i && !restart_i && cnt != LIM |=> cnt == $past(cnt) + 1'b1)
    else $error("filter count did not rise on fault");
  a_restart_clear: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R17
    restart_i |=> cnt == '0 && !filt_o)
    else $error("filter not cleared on restart");
  a_filt_full: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R13
    $rose(filt_o) |-> cnt == LIM && $past(fault_i))
    else $error("filter output rose before full count");
endmodule

/* tb/osd_bridge_model.sv */
// Behavioural model of three motor phases and their off-state comparators.
// Assumes the phases meet at a low-resistance star unless one is opened.
`timescale 1ns/100ps
module osd_bridge_model import osd_pkg::*; (
  input  wire logic [2:0] pu_en_i,      // Pull-up enables
  input  wire logic [2:0] pd_en_i,      // Pull-down enables
  input  wire logic [2:0] fault_mode_i, // 0 none, 1 gnd, 2 bat, 3..5 open ph1..3
  output logic      [2:0] ls_cmp_o,     // Above battery-short threshold
  output logic      [2:0] hs_cmp_o      // Above ground-short threshold
);
  logic       star_up;
  logic [1:0] lvl;

  always_comb begin
    star_up = 1'b0;
    lvl     = 2'd0;
    for (int p = 0; p < 3; p++) begin
      // The pull-up outweighs the pull-downs on the shared star point
      if (fault_mode_i != 3'(p + 3) && pu_en_i[p] && !pd_en_i[p]) begin
        star_up = 1'b1;
      end
    end
    for (int p = 0; p < 3; p++) begin
      // Level 0 ground, 1 forced mid level, 2 battery
      lvl = (fault_mode_i == 3'd1) ? 2'd0 :
            (fault_mode_i == 3'd2) ? 2'd2 :
            (fault_mode_i == 3'(p + 3)) ? {1'b0, pu_en_i[p] & ~pd_en_i[p]} :
            {1'b0, star_up};
      ls_cmp_o[p] = (lvl != 2'd0);
      hs_cmp_o[p] = (lvl == 2'd2);
    end
  end
endmodule

/* tb/test_osd_top.sv */
// Self-checking bench for the off-state phase diagnosis block.
// Assumes shortened filter and mask timers and the APB map of the block.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fails++; \
  $display("wrong value %s exp %0h got %0h", nm, ex, got); end end
module test_osd_top import osd_pkg::*;;
  localparam int FLT     = 8;
  localparam int BLK [4] = '{20, 30, 40, 50};
  logic         ref_clk_i  = 1'b0;
  logic         srst_i     = 1'b1;
  osd_apb_req_t apb_i      = '0;
  osd_apb_rsp_t apb_o;
  logic [2:0]   hs_drv_i   = 3'h0;
  logic [2:0]   ls_drv_i   = 3'h0;
  logic [2:0]   fault_mode = 3'h0;
  logic [2:0]   ls_cmp_i;
  logic [2:0]   hs_cmp_i;
  logic [2:0]   pu_en_o;
  logic [2:0]   pd_en_o;
  logic         irq_o;
  logic [31:0]  seed       = 32'h0000bd14;
  logic [31:0]  rd;
  logic         err;
  logic [3:0]   e;
  int           b;
  int           fails      = 0;
  int           tests_run  = 0;
  int           cycles     = 0;

  osd_top #(.FLT_LIM(FLT), .BLK0(20), .BLK1(30), .BLK2(40), .BLK3(50)) dut (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .apb_i(apb_i), .apb_o(apb_o),
    .hs_drv_i(hs_drv_i), .ls_drv_i(ls_drv_i), .ls_cmp_i(ls_cmp_i),
    .hs_cmp_i(hs_cmp_i), .pu_en_o(pu_en_o), .pd_en_o(pd_en_o), .irq_o(irq_o));

  osd_bridge_model bridge (.pu_en_i(pu_en_o), .pd_en_i(pd_en_o),
    .fault_mode_i(fault_mode), .ls_cmp_o(ls_cmp_i), .hs_cmp_o(hs_cmp_i));

  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Healthy flags {hs2, ls3, ls2, ls1} in the three-phase setup
  function automatic logic [3:0] exp_ok(input logic [2:0] m);
    case (m)
      3'd1:    return 4'b1000;
      3'd2:    return 4'b0111;
      3'd3:    return 4'b1110;
      3'd4:    return 4'b1010;
      3'd5:    return 4'b1011;
      default: return 4'b1111;
    endcase
  endfunction

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge ref_clk_i);
    apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: data};
    @(posedge ref_clk_i);
    apb_i.penable <= 1'b1;
    @(posedge ref_clk_i iff apb_o.pready);
    rd = apb_o.prdata;
    err = apb_o.pslverr;
    apb_i <= '0;
  endtask

  task automatic stop_test();
    if (fails == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole run needs well under this many cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    wt(16);
    srst_i <= 1'b0;
    wt(1);
    `CHK("pu_en", 3'h0, pu_en_o)
    `CHK("irq", 1'b0, irq_o)
    apb_xfer(1'b0, OFF_CTRL, 32'h0);
    `CHK("ctrl", 32'h80, rd)
    apb_xfer(1'b0, OFF_FLAGS, 32'h0);
    `CHK("flags", 13'h003f, rd[12:0])
    apb_xfer(1'b0, 8'h20, 32'h0);
    `CHK("slverr", 1'b1, err)
    `CHK("unmapped", 32'h0, rd)
    apb_xfer(1'b1, OFF_IMASK, 32'h1);
    for (int c = 0; c < 4; c++) begin
      apb_xfer(1'b1, OFF_CTRL, 32'(c));
      wt(8);
      `CHK("pu_en", {2'b0, c == 1}, pu_en_o)
      `CHK("pd_en", {2'b0, c == 2}, pd_en_o)
    end
    apb_xfer(1'b1, OFF_CTRL, 32'h1);
    wt(8);
    ls_drv_i <= 3'h1;
    wt(8);
    `CHK("pu stop ls", 3'h0, pu_en_o)
    ls_drv_i <= 3'h0;
    wt(8);
    `CHK("pu restart", 3'h1, pu_en_o)
    hs_drv_i <= 3'h1;
    wt(8);
    `CHK("pu stop hs", 3'h0, pu_en_o)
    hs_drv_i <= 3'h0;
    for (int m = 0; m < 6; m++) begin
      b = int'(next_rand() & 32'h3);
      e = exp_ok(3'(m));
      apb_xfer(1'b1, OFF_CTRL, 32'h0);
      fault_mode <= 3'(m);
      apb_xfer(1'b1, OFF_CLR, 32'h3f);
      apb_xfer(1'b1, OFF_ISTAT, 32'h3f);
      apb_xfer(1'b1, OFF_CTRL, 32'h26 | 32'(b << 6));
      wt(BLK[b] - 6);
      apb_xfer(1'b0, OFF_FLAGS, 32'h0);
      `CHK("blanked", 4'hf, {rd[4], rd[2:0]})
      `CHK("irq blank", 1'b0, irq_o)
      wt(40);
      apb_xfer(1'b0, OFF_FLAGS, 32'h0);
      `CHK("flags", e, {rd[4], rd[2:0]})
      `CHK("summary", 3'(m), rd[11:9])
      `CHK("setup", 1'b1, rd[12])
      `CHK("irq", ~e[0], irq_o)
      apb_xfer(1'b1, OFF_CLR, 32'h3f);
      apb_xfer(1'b0, OFF_FLAGS, 32'h0);
      `CHK("held", e, {rd[4], rd[2:0]})
      fault_mode <= 3'h0;
      wt(30);
      apb_xfer(1'b0, OFF_FLAGS, 32'h0);
      `CHK("latched", e, {rd[4], rd[2:0]})
      apb_xfer(1'b1, OFF_CLR, 32'h3f);
      apb_xfer(1'b0, OFF_FLAGS, 32'h0);
      `CHK("cleared", 4'hf, {rd[4], rd[2:0]})
      apb_xfer(1'b1, OFF_ISTAT, 32'h3f);
      wt(3);
      `CHK("irq clear", 1'b0, irq_o)
    end
    stop_test();
  end
endmodule
